// [verilog/atwsp_top.sv]
// Purpose: three-wire serial port with automatic buffer transfer
// Assumes: all pin inputs synchronous to CLK_IN
// Notes: buffer RAM lives here; cpu accesses to it win over the sequencer
// How it works
// R1: shift and drive output on falling clock
// R2: sample input on rising clock edge
// R3: eight bits, then stop and flag done
// R4: shift register write forces output low
// R5: direction bit reverses order at the gate
// R6: start needs enable and idle clock
// R7: enabling later does not start anything
// R8: clock from pin, timer, or prescaler
// R9: mode bit selects plain or automatic
// R10: input pin released when receive off
// R11: software clears handshake bits for external clock
// R12: automatic mode moves up to 32 bytes
// R13: software fills buffer upward from base
// R14: software loads pointer with count minus one
// R15: trigger write starts auto, value discarded
// R16: load buffer byte at pointer, then send
// R17: store received byte at pointer first
// R18: decrement pointer, end after address zero
// R19: active flag clears when auto ends
// R20: active flag clearing drives output low
// R21: done flag set after last byte
// R22: wait gap while cpu holds the RAM
// R23: disable stops, clears counter, frees pins
// R24: busy enable and polarity decoding
// R25: active flag read-only, set by trigger
// R26: repeat bit reloads pointer and continues
// R27: error check only with busy enabled
`timescale 1ns/10ps
`default_nettype none
`include "atwsp_params.svh"

module atwsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;
    assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem[rp_r];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_r] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // atwsp_fifo

module atwsp_top #(
    parameter int BUF_DEPTH  = 32,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    // cpu register port
    input  wire logic [15:0] CPU_ADDR_IN,
    input  wire logic        CPU_WR_IN,
    input  wire logic        CPU_RD_IN,
    input  wire logic [7:0]  CPU_WDATA_IN,
    output logic      [7:0]  CPU_RDATA_OUT,
    output logic             CPU_RVALID_OUT,
    // serial pins
    input  wire logic        SCK_IN,
    output logic             SCK_OUT,
    output logic             SCK_OE_OUT,
    output logic             SO_OUT,
    output logic             SO_OE_OUT,
    input  wire logic        SI_IN,
    output logic             SI_RELEASE_OUT,
    // clock sources and handshake
    input  wire logic        TIMER2_IN,
    input  wire logic        BUSY_IN,
    // completion
    input  wire logic        DONE_CLEAR_IN,
    output logic             DONE_FLAG_OUT,
    output logic             DONE_PULSE_OUT,
    output logic             AUTO_ACTIVE_OUT
);
    localparam int PW = $clog2(BUF_DEPTH);
    if (BUF_DEPTH < 2 || BUF_DEPTH > 32 || (1 << PW) != BUF_DEPTH) begin : g_bad_buf
        $error("buffer depth must be a power of two up to 32");
    end
    localparam logic [15:0] RAM_BASE = `ATWSP_RAM_BASE;

    logic [7:0]   mode_r;
    logic [7:0]   actl_r;
    logic [7:0]   presc_r;
    logic [7:0]   sr_r;
    logic [3:0]   cnt_r;
    logic [PW-1:0] ptr_r;
    logic [PW-1:0] ptr_init_r;
    logic         trf_r;
    logic         err_r;
    logic         so_r;
    logic         sck_r;
    logic         sck_prev_r;
    logic         done_pulse_r;
    logic         done_flag_r;
    logic [15:0]  presc_cnt_r;
    logic         presc_prev_r;
    logic         presc_tick_r;
    logic [7:0]   ram [0:BUF_DEPTH-1];
    atwsp_pkg::atwsp_state_t state_r;

    // decode
    logic ram_hit;
    logic sio_wr;
    logic en;
    logic ext;
    logic start_ok;
    logic tick;
    logic busy_act;
    logic hold;
    logic fall_ev;
    logic rise_ev;
    logic last_bit;
    logic advance;
    logic [7:0] rx_byte;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [PW+7:0] fifo_out;

    assign ram_hit  = (CPU_WR_IN | CPU_RD_IN) & (CPU_ADDR_IN[15:PW] == RAM_BASE[15:PW]);
    assign sio_wr   = CPU_WR_IN & (CPU_ADDR_IN == `ATWSP_SHIFT_ADDR);
    assign en       = mode_r[`ATWSP_M_EN];
    assign ext      = ~mode_r[`ATWSP_M_CSH];
    assign start_ok = en & (ext ? SCK_IN : 1'b1) & (state_r == atwsp_pkg::ST_IDLE); // R6
    assign tick     = mode_r[`ATWSP_M_CSL] ? presc_tick_r : TIMER2_IN; // R8
    // busy input: unused, active high, or active low
    assign busy_act = actl_r[`ATWSP_A_BUSYEN] & (BUSY_IN ^ actl_r[`ATWSP_A_BUSYPOL]); // R24
    // busy only holds the clock before the first bit, never mid-byte
    assign hold     = busy_act & (cnt_r == 4'h0) & sck_r;
    assign fall_ev  = (state_r == atwsp_pkg::ST_SHIFT) &
                      (ext ? (sck_prev_r & ~SCK_IN) : (tick & sck_r & ~hold));
    assign rise_ev  = (state_r == atwsp_pkg::ST_SHIFT) &
                      (ext ? (~sck_prev_r & SCK_IN) : (tick & ~sck_r));
    assign last_bit = rise_ev & (cnt_r == `ATWSP_LAST_BIT);
    assign advance  = (state_r == atwsp_pkg::ST_STORE) & (~actl_r[`ATWSP_A_RE] | fifo_in_ready);
    assign rx_byte  = mode_r[`ATWSP_M_DIR] ? atwsp_pkg::atwsp_rev8(sr_r) : sr_r; // R5

    // received bytes queue here so the cpu can keep the RAM busy
    atwsp_fifo #(
        .WIDTH (PW + 8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in        (CLK_IN),
        .rst_n_in      (RST_N_IN),
        .in_valid_in   ((state_r == atwsp_pkg::ST_STORE) & actl_r[`ATWSP_A_RE]),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    ({ptr_r, rx_byte}),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (~ram_hit),
        .out_data_out  (fifo_out)
    );

    // control registers
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode_r  <= `ATWSP_MODE_RST;
            actl_r  <= `ATWSP_AUTO_RST;
            presc_r <= `ATWSP_PRESC_RST;
        end else if (CPU_WR_IN) begin
            if (CPU_ADDR_IN == `ATWSP_MODE_ADDR) begin
                mode_r <= CPU_WDATA_IN & `ATWSP_MODE_WMASK; // R9
            end
            if (CPU_ADDR_IN == `ATWSP_AUTO_ADDR) begin
                actl_r <= CPU_WDATA_IN & `ATWSP_AUTO_WMASK;
            end
            if (CPU_ADDR_IN == `ATWSP_PRESC_ADDR) begin
                presc_r <= CPU_WDATA_IN;
            end
        end
    end

    // buffer RAM: cpu first, then queued receive bytes
    always_ff @(posedge CLK_IN) begin
        if (CPU_WR_IN & ram_hit) begin
            ram[CPU_ADDR_IN[PW-1:0]] <= CPU_WDATA_IN;
        end else if (fifo_out_valid) begin
            ram[fifo_out[PW+7:8]] <= fifo_out[7:0]; // R17
        end
    end

    // read port, one cycle latency
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            CPU_RDATA_OUT  <= 8'h00;
            CPU_RVALID_OUT <= 1'b0;
        end else begin
            CPU_RVALID_OUT <= CPU_RD_IN;
            CPU_RDATA_OUT  <= 8'h00;
            if (CPU_RD_IN) begin
                if (ram_hit) begin
                    CPU_RDATA_OUT <= ram[CPU_ADDR_IN[PW-1:0]];
                end else begin
                    case (CPU_ADDR_IN)
                        `ATWSP_MODE_ADDR:  CPU_RDATA_OUT <= mode_r;
                        `ATWSP_AUTO_ADDR:  CPU_RDATA_OUT <= actl_r | ({7'h00, err_r} << `ATWSP_A_ERR)
                                                           | ({7'h00, trf_r} << `ATWSP_A_TRF); // R25
                        `ATWSP_SHIFT_ADDR: CPU_RDATA_OUT <= rx_byte; // R5
                        `ATWSP_PTR_ADDR:   CPU_RDATA_OUT <= {{(8-PW){1'b0}}, ptr_r};
                        `ATWSP_PRESC_ADDR: CPU_RDATA_OUT <= presc_r;
                        default:           CPU_RDATA_OUT <= 8'h00;
                    endcase
                end
            end
        end
    end

    // prescaler: tick at each rise of the selected counter bit
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            presc_cnt_r  <= 16'h0000;
            presc_prev_r <= 1'b0;
            presc_tick_r <= 1'b0;
        end else begin
            presc_cnt_r  <= presc_cnt_r + 16'h0001;
            presc_prev_r <= presc_cnt_r[presc_r[7:4]];
            presc_tick_r <= presc_cnt_r[presc_r[7:4]] & ~presc_prev_r; // R8
        end
    end

    // serial clock and pin ownership
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sck_r          <= 1'b1;
            sck_prev_r     <= 1'b1;
            SCK_OE_OUT     <= 1'b0;
            SO_OE_OUT      <= 1'b0;
            SI_RELEASE_OUT <= 1'b1;
        end else begin
            sck_prev_r     <= SCK_IN;
            SCK_OE_OUT     <= en & ~ext; // R23
            SO_OE_OUT      <= en; // R23
            SI_RELEASE_OUT <= ~(en & actl_r[`ATWSP_A_RE]); // R10
            if (!en || state_r != atwsp_pkg::ST_SHIFT) begin
                sck_r <= 1'b1;
            end else if (!ext && (fall_ev || rise_ev)) begin
                sck_r <= ~sck_r;
            end
        end
    end
    assign SCK_OUT         = sck_r;
    assign SO_OUT          = so_r;
    assign AUTO_ACTIVE_OUT = trf_r;
    assign DONE_PULSE_OUT  = done_pulse_r;
    assign DONE_FLAG_OUT   = done_flag_r;

    // sequencer
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_r      <= atwsp_pkg::ST_IDLE;
            sr_r         <= 8'h00;
            cnt_r        <= 4'h0;
            ptr_r        <= '0;
            ptr_init_r   <= '0;
            trf_r        <= 1'b0;
            err_r        <= 1'b0;
            so_r         <= 1'b0;
            done_pulse_r <= 1'b0;
        end else begin
            done_pulse_r <= 1'b0;
            if (CPU_WR_IN && CPU_ADDR_IN == `ATWSP_PTR_ADDR) begin
                ptr_r <= CPU_WDATA_IN[PW-1:0];
            end
            if (!en && state_r != atwsp_pkg::ST_IDLE) begin
                state_r <= atwsp_pkg::ST_IDLE; // R23
                cnt_r   <= 4'h0; // R23
                trf_r   <= 1'b0; // R19
                so_r    <= 1'b0; // R20
            end else begin
                case (state_r)
                    atwsp_pkg::ST_IDLE: begin
                        if (sio_wr) begin
                            so_r  <= 1'b0; // R4
                            cnt_r <= 4'h0;
                            if (start_ok && mode_r[`ATWSP_M_AUTO]) begin
                                trf_r      <= 1'b1; // R25
                                err_r      <= 1'b0;
                                ptr_init_r <= ptr_r;
                                state_r    <= atwsp_pkg::ST_LOAD; // R15
                            end else begin
                                sr_r <= mode_r[`ATWSP_M_DIR] ? atwsp_pkg::atwsp_rev8(CPU_WDATA_IN)
                                                             : CPU_WDATA_IN; // R5
                                if (start_ok) begin
                                    state_r <= atwsp_pkg::ST_SHIFT; // R7
                                end
                            end
                        end
                    end
                    atwsp_pkg::ST_LOAD: begin
                        // gap stretches while the cpu or pending stores hold the RAM
                        if (!ram_hit && !fifo_out_valid) begin // R22
                            sr_r    <= mode_r[`ATWSP_M_DIR] ? atwsp_pkg::atwsp_rev8(ram[ptr_r])
                                                            : ram[ptr_r]; // R16
                            cnt_r   <= 4'h0;
                            state_r <= atwsp_pkg::ST_SHIFT;
                        end
                    end
                    atwsp_pkg::ST_SHIFT: begin
                        if (fall_ev) begin
                            so_r <= sr_r[7]; // R1
                            sr_r <= {sr_r[6:0], sr_r[0]}; // R1
                        end
                        if (rise_ev) begin
                            sr_r[0] <= SI_IN; // R2
                            cnt_r   <= cnt_r + 4'h1;
                        end
                        if (last_bit) begin
                            cnt_r <= 4'h0;
                            if (trf_r) begin
                                state_r <= atwsp_pkg::ST_STORE; // R12
                            end else begin
                                state_r      <= atwsp_pkg::ST_IDLE; // R3
                                done_pulse_r <= 1'b1; // R3
                            end
                        end
                    end
                    atwsp_pkg::ST_STORE: begin
                        if (advance) begin
                            if (actl_r[`ATWSP_A_ERROR_CHECK_ENABLE] && actl_r[`ATWSP_A_BUSYEN] && busy_act) begin
                                err_r <= 1'b1; // R27
                            end
                            if ({{(8-PW){1'b0}}, ptr_r} != `ATWSP_PTR_LAST) begin
                                ptr_r   <= ptr_r - 1'b1; // R18
                                state_r <= atwsp_pkg::ST_LOAD;
                            end else if (actl_r[`ATWSP_A_RPT]) begin
                                ptr_r   <= ptr_init_r; // R26
                                state_r <= atwsp_pkg::ST_LOAD;
                            end else begin
                                trf_r        <= 1'b0; // R19
                                so_r         <= 1'b0; // R20
                                done_pulse_r <= 1'b1; // R21
                                state_r      <= atwsp_pkg::ST_IDLE; // R18
                            end
                        end
                    end
                    default: state_r <= atwsp_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // sticky done flag, a new event beats a clear
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            done_flag_r <= 1'b0;
        end else begin
            done_flag_r <= done_pulse_r | (done_flag_r & ~DONE_CLEAR_IN); // R3
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    property p_fall_out;
        fall_ev |=> (so_r == $past(sr_r[7]));
    endproperty
    a_fall_out: assert property (p_fall_out) else $error("output bit not taken on fall"); // R1

    property p_rise_in;
        (rise_ev && en) |=> (sr_r[0] == $past(SI_IN));
    endproperty
    a_rise_in: assert property (p_rise_in) else $error("input bit not sampled on rise"); // R2

    property p_plain_done;
        (last_bit && !trf_r && en) |=> (done_pulse_r && state_r == atwsp_pkg::ST_IDLE) ##1 done_flag_r;
    endproperty
    a_plain_done: assert property (p_plain_done) else $error("plain byte end not flagged"); // R3

    property p_wr_low;
        (sio_wr && state_r == atwsp_pkg::ST_IDLE) |=> !so_r;
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("output not low after write"); // R4

    property p_no_start;
        (sio_wr && !en) |=> (state_r == atwsp_pkg::ST_IDLE);
    endproperty
    a_no_start: assert property (p_no_start) else $error("start while disabled"); // R7

    property p_trigger;
        (sio_wr && start_ok && mode_r[`ATWSP_M_AUTO]) |=> (trf_r && state_r == atwsp_pkg::ST_LOAD);
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger did not start auto"); // R25

    property p_end_low;
        $fell(trf_r) |-> !so_r;
    endproperty
    a_end_low: assert property (p_end_low) else $error("output not low at auto end"); // R20

    property p_ptr_dec;
        (advance && en && ptr_r != '0 && !CPU_WR_IN) |=> (ptr_r == $past(ptr_r) - 1'b1);
    endproperty
    a_ptr_dec: assert property (p_ptr_dec) else $error("pointer not decremented"); // R18

    property p_disable;
        !en |=> (!SCK_OE_OUT && !SO_OE_OUT && SI_RELEASE_OUT);
    endproperty
    a_disable: assert property (p_disable) else $error("pins held while disabled"); // R23
endmodule // atwsp_top
`default_nettype wire

// [verilog/atwsp_params.svh]
// Purpose: offsets, field positions and reset values of the serial port
// Assumes: byte-wide register port of the host processor
// Notes: definitions only
`ifndef ATWSP_PARAMS_SVH
`define ATWSP_PARAMS_SVH
// register offsets
`define ATWSP_MODE_ADDR   16'hFF68
`define ATWSP_AUTO_ADDR   16'hFF69
`define ATWSP_SHIFT_ADDR  16'hFF6A
`define ATWSP_PTR_ADDR    16'hFF6B
`define ATWSP_PRESC_ADDR  16'hFF6C
`define ATWSP_RAM_BASE    16'hFAC0
// serial_mode_control fields
`define ATWSP_M_EN        7
`define ATWSP_M_DIR       6
`define ATWSP_M_AUTO      5
`define ATWSP_M_CSH       1
`define ATWSP_M_CSL       0
`define ATWSP_MODE_WMASK  8'hE3
// auto_transfer_control fields
`define ATWSP_A_RE        7
`define ATWSP_A_RPT       6
`define ATWSP_A_ERROR_CHECK_ENABLE      5
`define ATWSP_A_ERR       4
`define ATWSP_A_TRF       3
`define ATWSP_A_STROBE_ENABLE      2
`define ATWSP_A_BUSYEN    1
`define ATWSP_A_BUSYPOL   0
`define ATWSP_AUTO_WMASK  8'hE7
// reset values
`define ATWSP_MODE_RST    8'h00
`define ATWSP_AUTO_RST    8'h00
`define ATWSP_PRESC_RST   8'h88
// counts
`define ATWSP_LAST_BIT    4'h7
`define ATWSP_PTR_LAST    8'h00
`endif

// [verilog/atwsp_pkg.sv]
// Purpose: types shared by the serial port
// Assumes: nothing
// Notes: bit reversal models the read/write gate
package atwsp_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LOAD  = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_STORE = 4'b1000
    } atwsp_state_t;

    function automatic logic [7:0] atwsp_rev8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction
endpackage

// [verification/atwsp_peer.sv]
// Purpose: peripheral chip on the far side of the three-wire link
// Assumes: link clock comes from the port, or from the bench in external clock mode, data changes on falling edges
// Notes: reply byte for transfer n is 3C xor n; every received byte is logged in got
`timescale 1ns/10ps
`default_nettype none

module atwsp_peer (
    // reset
    input  wire logic rst_n_in,
    // link
    input  wire logic sck_in,
    input  wire logic so_in,
    output logic      si_out
);
    // the bench reset only rises, so the counters start from known values here
    logic [7:0] n_bytes = 8'h00;
    logic [2:0] bit_c   = 3'h0;
    logic [7:0] rx_r    = 8'h00;
    logic [7:0] rep;
    logic [7:0] got [0:255];

    assign rep = 8'h3C ^ n_bytes;

    // reply bits leave msb first, a full half period before the port samples them
    always @(negedge sck_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            si_out <= 1'b0;
        end else begin
            si_out <= rep[3'h7 - bit_c];
        end
    end

    always @(posedge sck_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            n_bytes <= 8'h00;
            bit_c   <= 3'h0;
            rx_r    <= 8'h00;
        end else begin
            rx_r  <= {rx_r[6:0], so_in};
            bit_c <= bit_c + 3'h1;
            if (bit_c == 3'h7) begin
                got[n_bytes] <= {rx_r[6:0], so_in};
                n_bytes      <= n_bytes + 8'h01;
            end
        end
    end
endmodule // atwsp_peer

`default_nettype wire

// [verification/test_auto_three_wire_serial_port.sv]
// Purpose: self-checking bench for the serial port
// Assumes: prescaler and timer ticks every 4 cycles, external clock half period of 3 cycles
// Notes: busy input stays inactive, handshake is not exercised
`timescale 1ns/10ps
`default_nettype none

module test_auto_three_wire_serial_port;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        sck_out;
    logic        sck_oe;
    logic        so;
    logic        so_oe;
    logic        si;
    logic        si_rel;
    logic        tick = 1'b0;
    logic [1:0]  tcnt = 2'h0;
    logic        done_clr = 1'b0;
    logic        done_flag;
    logic        done_pulse;
    logic        auto_act;
    logic        ext_sck = 1'b1;
    logic [7:0]  n_pulse = 8'h00;
    logic [7:0]  p_seen = 8'h00;
    wire         sck_pin;
    int          n_fail = 0;
    int          checked = 0;

    // an undriven clock line follows the bench's external clock, which idles high
    assign sck_pin = sck_oe ? sck_out : ext_sck;

    always @(posedge clk) begin
        if (done_pulse === 1'b1) begin
            n_pulse <= n_pulse + 8'h01;
        end
    end

    always #25 clk = ~clk;

    always @(posedge clk) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h0);
    end

    atwsp_top dut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CPU_ADDR_IN(addr), .CPU_WR_IN(wr_en), .CPU_RD_IN(rd_en),
        .CPU_WDATA_IN(wdata), .CPU_RDATA_OUT(rdata), .CPU_RVALID_OUT(rvalid), .SCK_IN(sck_pin),
        .SCK_OUT(sck_out), .SCK_OE_OUT(sck_oe), .SO_OUT(so), .SO_OE_OUT(so_oe), .SI_IN(si),
        .SI_RELEASE_OUT(si_rel), .TIMER2_IN(tick), .BUSY_IN(1'b0), .DONE_CLEAR_IN(done_clr),
        .DONE_FLAG_OUT(done_flag), .DONE_PULSE_OUT(done_pulse), .AUTO_ACTIVE_OUT(auto_act)
    );

    atwsp_peer peer (.rst_n_in(rst_n), .sck_in(sck_pin), .so_in(so), .si_out(si));

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [7:0] flip(input logic [7:0] d);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check("rvalid", rvalid, 8'h01);
        d = rdata;
    endtask

    task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(nm, d, exp);
    endtask

    // bounded wait: which 0 waits for the done flag, 1 for the end of automatic mode
    task automatic wait_for(input int which);
        int i;
        i = 0;
        while (((which == 0) ? (done_flag !== 1'b1) : (auto_act !== 1'b0)) && i < 4000) begin
            @(posedge clk);
            i++;
        end
        #1;
        check("wait", (i < 4000), 8'h01);
    endtask

    task automatic clear_done;
        @(posedge clk);
        done_clr <= 1'b1;
        @(posedge clk);
        done_clr <= 1'b0;
        @(posedge clk);
        #1;
        check("done cleared", done_flag, 8'h00);
        check("one pulse", n_pulse - p_seen, 8'h01);
        p_seen = n_pulse;
    endtask

    task automatic t_ext(input logic [7:0] v);
        logic [7:0] n0;
        wr(16'hFF69, 8'h80);
        wr(16'hFF68, 8'h80);
        n0 = peer.n_bytes;
        wr(16'hFF6A, v);
        repeat (8) begin
            repeat (3) @(posedge clk);
            ext_sck <= 1'b0;
            repeat (3) @(posedge clk);
            ext_sck <= 1'b1;
        end
        wait_for(0);
        check("ext sent", peer.got[n0], v);
        rd_chk("ext received", 16'hFF6A, 8'h3C ^ n0);
        clear_done();
    endtask

    task automatic t_reset;
        rd_chk("mode rst", 16'hFF68, 8'h00);
        rd_chk("auto rst", 16'hFF69, 8'h00);
        rd_chk("presc rst", 16'hFF6C, 8'h88);
        rd_chk("unmapped", 16'hFF70, 8'h00);
        check("si free", si_rel, 8'h01);
        check("so idle", so_oe, 8'h00);
        wr(16'hFF68, 8'h1C);
        rd_chk("mode mask", 16'hFF68, 8'h00);
    endtask

    task automatic t_plain(input logic [1:0] csel, input logic dir, input logic [7:0] v);
        logic [7:0] n0;
        logic [7:0] rep;
        wr(16'hFF68, {1'b1, dir, 4'h0, csel});
        n0  = peer.n_bytes;
        rep = 8'h3C ^ n0;
        wr(16'hFF6A, v);
        #1;
        check("so low on write", so, 8'h00);
        wait_for(0);
        check("sent", peer.got[n0], dir ? flip(v) : v);
        check("one byte", peer.n_bytes, n0 + 8'h01);
        rd_chk("received", 16'hFF6A, dir ? flip(rep) : rep);
        check("clock idle", sck_out, 8'h01);
        clear_done();
    endtask

    task automatic t_late_enable;
        logic [7:0] n0;
        n0 = peer.n_bytes;
        wr(16'hFF68, 8'h03);
        wr(16'hFF6A, 8'h5A);
        wr(16'hFF68, 8'h83);
        repeat (60) @(posedge clk);
        check("no start", peer.n_bytes, n0);
        check("no done", done_flag, 8'h00);
    endtask

    task automatic t_auto;
        logic [7:0] n0;
        logic [7:0] d;
        wr(16'hFAC0, 8'h11);
        wr(16'hFAC1, 8'h22);
        wr(16'hFAC2, 8'h33);
        wr(16'hFF6B, 8'h02);
        wr(16'hFF68, 8'hA3);
        n0 = peer.n_bytes;
        wr(16'hFF6A, 8'hEE);
        @(posedge clk);
        #1;
        check("active set", auto_act, 8'h01);
        rd(16'hFF69, d);
        check("active bit", d & 8'h08, 8'h08);
        wait_for(1);
        check("so low at end", so, 8'h00);
        check("done at end", done_flag, 8'h01);
        check("bytes", peer.n_bytes, n0 + 8'h03);
        check("tx first", peer.got[n0], 8'h33);
        check("tx mid", peer.got[n0 + 8'h01], 8'h22);
        check("tx last", peer.got[n0 + 8'h02], 8'h11);
        rd_chk("rx first", 16'hFAC2, 8'h3C ^ n0);
        rd_chk("rx mid", 16'hFAC1, 8'h3C ^ (n0 + 8'h01));
        rd_chk("rx last", 16'hFAC0, 8'h3C ^ (n0 + 8'h02));
        clear_done();
    endtask

    task automatic t_release;
        wr(16'hFF68, 8'h83);
        @(posedge clk);
        #1;
        check("si in use", si_rel, 8'h00);
        wr(16'hFF69, 8'h00);
        @(posedge clk);
        #1;
        check("si released", si_rel, 8'h01);
        wr(16'hFF68, 8'h03);
        @(posedge clk);
        #1;
        check("so port", so_oe, 8'h00);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        wr(16'hFF6C, 8'h10);
        wr(16'hFF69, 8'h80);
        t_plain(2'b11, 1'b0, 8'hA5);
        t_plain(2'b11, 1'b1, 8'h1E);
        t_plain(2'b10, 1'b0, 8'hC3);
        t_late_enable();
        t_auto();
        t_release();
        t_ext(8'h96);
        print_verdict();
    end
endmodule // test_auto_three_wire_serial_port

`default_nettype wire
